// file: cmp_pkg.sv
// constants for the channel mode programmer: pin slots, register map, reset values
package cmp_pkg;

    // ------------------------------------------------------------
    // synchronised pin slots
    // ------------------------------------------------------------
    localparam int PIN_W      = 5;     // number of pins passing the synchroniser
    localparam int PIN_SWITCH = 0;     // isolated_switch_control
    localparam int PIN_SCLK   = 1;     // shift_clock_line
    localparam int PIN_SDATA  = 2;     // serial_data_line
    localparam int PIN_CLEAR  = 3;     // register_clear_line (rc derived)
    localparam int PIN_MUXHI  = 4;     // third channel-select bit, straight to the mux
    // idle pin levels (switch, shift clock and clear high); the synchroniser resets to
    // these so that no false shift-clock edge follows reset
    localparam logic [PIN_W-1:0] PIN_IDLE = 5'h0b;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int CH_N   = 8;         // channels, one mode bit each
    localparam int SEL_W  = 3;         // 8:1 multiplexer select
    localparam int CFG_W  = 16;        // converter configuration word
    localparam int ADDR_W = 8;         // axi4-lite address bits decoded

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h00;  // ro: modes and line levels
    localparam logic [ADDR_W-1:0] REG_CONV   = 8'h04;  // rw: converter configuration
    localparam logic [ADDR_W-1:0] REG_SHIFT  = 8'h08;  // ro: shift stage contents

    // status field positions
    localparam int ST_MODES   = 0;     // [7:0] applied channel modes
    localparam int ST_CONVRST = 8;     // converter held in reset
    localparam int ST_CLEAR   = 9;     // clear line level
    localparam int ST_SWITCH  = 10;    // switch control level
    localparam int ST_MUXSEL  = 11;    // [13:11] current mux select

    // reset values
    localparam logic [CFG_W-1:0] CONV_CFG_DEFAULT = 16'h0000;  // converter power-on setup
    localparam logic [CH_N-1:0]  MODES_RESET      = 8'h00;     // all voltage sensing
    localparam logic [SEL_W-1:0] MUXSEL_RESET     = 3'h0;

    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : cmp_pkg

// file: cmp_mode_programmer.sv
// channel mode programmer: pin synchroniser, switch routing, mode register, axi4-lite slave
//
// The AXI4-Lite register port and the placing of the registers are this design's own decisions.
module cmp_mode_programmer
(
    input  wire logic                           sys_clk,
    input  wire logic                           reset,
    // isolated programming pins, asynchronous to sys_clk
    input  wire logic                           isolated_switch_control,
    input  wire logic                           shift_clock_line,
    input  wire logic                           serial_data_line,
    input  wire logic                           register_clear_line,
    input  wire logic                           channel_select_high,
    // analog side controls
    output logic [cmp_pkg::SEL_W-1:0]           mux_select,
    output logic                                converter_reset_n,
    output logic [cmp_pkg::CFG_W-1:0]           converter_config,
    output logic [cmp_pkg::CH_N-1:0]            opto_drive,
    output logic [cmp_pkg::CH_N-1:0]            indicator_left_to_right,
    // axi4-lite slave
    input  wire logic [cmp_pkg::ADDR_W-1:0]     s_axi_awaddr,
    input  wire logic                           s_axi_awvalid,
    output logic                                s_axi_awready,
    input  wire logic [31:0]                    s_axi_wdata,
    input  wire logic [3:0]                     s_axi_wstrb,
    input  wire logic                           s_axi_wvalid,
    output logic                                s_axi_wready,
    output logic [1:0]                          s_axi_bresp,
    output logic                                s_axi_bvalid,
    input  wire logic                           s_axi_bready,
    input  wire logic [cmp_pkg::ADDR_W-1:0]     s_axi_araddr,
    input  wire logic                           s_axi_arvalid,
    output logic                                s_axi_arready,
    output logic [31:0]                         s_axi_rdata,
    output logic [1:0]                          s_axi_rresp,
    output logic                                s_axi_rvalid,
    input  wire logic                           s_axi_rready
);

    // ------------------------------------------------------------
    // pin synchroniser
    // ------------------------------------------------------------
    logic [cmp_pkg::PIN_W-1:0] pin_meta_ff;   // first stage, read only by second stage
    logic [cmp_pkg::PIN_W-1:0] pin_sync_ff;   // usable pin levels
    logic [cmp_pkg::PIN_W-1:0] pin_prev_ff;   // one cycle older, for edge detection
    logic [cmp_pkg::PIN_W-1:0] pin_raw;

    assign pin_raw = {channel_select_high, register_clear_line, serial_data_line,
                      shift_clock_line, isolated_switch_control};

    // plain two-flop chain; all pins treated alike so skew between them is at most a cycle
    // reset to the idle levels: a zero reset would show a false shift-clock rise, and
    // with pin skew that rise could meet a low switch and shift a stray bit
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            pin_meta_ff <= cmp_pkg::PIN_IDLE;
            pin_sync_ff <= cmp_pkg::PIN_IDLE;
            pin_prev_ff <= cmp_pkg::PIN_IDLE;
        end
        else
        begin
            pin_meta_ff <= pin_raw;
            pin_sync_ff <= pin_meta_ff;
            pin_prev_ff <= pin_sync_ff;
        end
    end

    logic switch_s;     // high: lines go to mux; low: lines go to mode register
    logic clear_s;      // derived clear level, low clears the applied modes
    logic sclk_rise;    // rising edge of the shift clock line

    assign switch_s  = pin_sync_ff[cmp_pkg::PIN_SWITCH];
    assign clear_s   = pin_sync_ff[cmp_pkg::PIN_CLEAR];
    assign sclk_rise = pin_sync_ff[cmp_pkg::PIN_SCLK] & ~pin_prev_ff[cmp_pkg::PIN_SCLK];

    // ------------------------------------------------------------
    // analog switch routing and converter reset
    // ------------------------------------------------------------
    logic [cmp_pkg::SEL_W-1:0] mux_sel_ff;
    logic [cmp_pkg::SEL_W-1:0] nxt_mux_sel;
    logic                      conv_rst_n_ff;
    logic                      nxt_conv_rst_n;

    // mux follows the two lines only while routed there; it holds during programming
    // so the shift traffic never scrambles the selected channel
    always_comb
    begin
        nxt_mux_sel    = mux_sel_ff;
        nxt_conv_rst_n = switch_s;
        if (switch_s)
        begin
            nxt_mux_sel = {pin_sync_ff[cmp_pkg::PIN_MUXHI],
                           pin_sync_ff[cmp_pkg::PIN_SDATA],
                           pin_sync_ff[cmp_pkg::PIN_SCLK]};
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            mux_sel_ff    <= cmp_pkg::MUXSEL_RESET;
            conv_rst_n_ff <= 1'b0;
        end
        else
        begin
            mux_sel_ff    <= nxt_mux_sel;
            conv_rst_n_ff <= nxt_conv_rst_n;
        end
    end

    // ------------------------------------------------------------
    // mode register: shift stage plus applied (storage) stage
    // ------------------------------------------------------------
    logic [cmp_pkg::CH_N-1:0] shift_ff;    // bits being shifted in, msb first
    logic [cmp_pkg::CH_N-1:0] modes_ff;    // applied modes, 1 = current sensing
    logic [cmp_pkg::CH_N-1:0] nxt_shift;
    logic [cmp_pkg::CH_N-1:0] nxt_modes;

    // storage clocks with the shift stage, so it captures the pre-shift contents;
    // that is why one extra pulse after clear rises is what applies the byte
    always_comb
    begin
        nxt_shift = shift_ff;
        nxt_modes = modes_ff;
        if (!switch_s && sclk_rise)
        begin
            nxt_shift = {shift_ff[cmp_pkg::CH_N-2:0],
                         pin_sync_ff[cmp_pkg::PIN_SDATA]};
            nxt_modes = shift_ff;
        end
        if (!clear_s)
        begin
            nxt_modes = cmp_pkg::MODES_RESET;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            shift_ff <= '0;
            modes_ff <= cmp_pkg::MODES_RESET;
        end
        else
        begin
            shift_ff <= nxt_shift;
            modes_ff <= nxt_modes;
        end
    end

    // ------------------------------------------------------------
    // converter configuration, lost whenever the converter is reset
    // ------------------------------------------------------------
    logic [cmp_pkg::CFG_W-1:0] conv_cfg_ff;
    logic [cmp_pkg::CFG_W-1:0] nxt_conv_cfg;
    logic                      wr_fire;      // write address and data both held
    logic [cmp_pkg::ADDR_W-1:0] awaddr_ff;
    logic [31:0]               wdata_ff;
    logic [3:0]                wstrb_ff;

    // a write during converter reset is answered but has no effect: reset wins
    always_comb
    begin
        nxt_conv_cfg = conv_cfg_ff;
        if (wr_fire && awaddr_ff == cmp_pkg::REG_CONV)
        begin
            for (int b = 0; b < cmp_pkg::CFG_W / 8; b++)
            begin
                if (wstrb_ff[b])
                begin
                    nxt_conv_cfg[b*8 +: 8] = wdata_ff[b*8 +: 8];
                end
            end
        end
        if (!conv_rst_n_ff)
        begin
            nxt_conv_cfg = cmp_pkg::CONV_CFG_DEFAULT;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            conv_cfg_ff <= cmp_pkg::CONV_CFG_DEFAULT;
        end
        else
        begin
            conv_cfg_ff <= nxt_conv_cfg;
        end
    end

    // ------------------------------------------------------------
    // axi4-lite write channel
    // ------------------------------------------------------------
    logic aw_held_ff;
    logic w_held_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic nxt_aw_held;
    logic nxt_w_held;
    logic nxt_bvalid;
    logic [1:0] nxt_bresp;
    logic [cmp_pkg::ADDR_W-1:0] nxt_awaddr;
    logic [31:0] nxt_wdata;
    logic [3:0]  nxt_wstrb;

    assign s_axi_awready = ~aw_held_ff & ~bvalid_ff;
    assign s_axi_wready  = ~w_held_ff & ~bvalid_ff;
    assign wr_fire       = aw_held_ff & w_held_ff & ~bvalid_ff;

    // address and data are caught in either order; the write acts once both are in
    always_comb
    begin
        nxt_aw_held = aw_held_ff;
        nxt_w_held  = w_held_ff;
        nxt_bvalid  = bvalid_ff;
        nxt_bresp   = bresp_ff;
        nxt_awaddr  = awaddr_ff;
        nxt_wdata   = wdata_ff;
        nxt_wstrb   = wstrb_ff;
        if (s_axi_awvalid && s_axi_awready)
        begin
            nxt_aw_held = 1'b1;
            nxt_awaddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            nxt_w_held = 1'b1;
            nxt_wdata  = s_axi_wdata;
            nxt_wstrb  = s_axi_wstrb;
        end
        if (wr_fire)
        begin
            nxt_aw_held = 1'b0;
            nxt_w_held  = 1'b0;
            nxt_bvalid  = 1'b1;
            // only the configuration word is writable; the others refuse
            nxt_bresp   = (awaddr_ff == cmp_pkg::REG_CONV) ? cmp_pkg::RESP_OKAY
                                                           : cmp_pkg::RESP_SLVERR;
        end
        else if (bvalid_ff && s_axi_bready)
        begin
            nxt_bvalid = 1'b0;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            aw_held_ff <= 1'b0;
            w_held_ff  <= 1'b0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= cmp_pkg::RESP_OKAY;
            awaddr_ff  <= '0;
            wdata_ff   <= '0;
            wstrb_ff   <= '0;
        end
        else
        begin
            aw_held_ff <= nxt_aw_held;
            w_held_ff  <= nxt_w_held;
            bvalid_ff  <= nxt_bvalid;
            bresp_ff   <= nxt_bresp;
            awaddr_ff  <= nxt_awaddr;
            wdata_ff   <= nxt_wdata;
            wstrb_ff   <= nxt_wstrb;
        end
    end

    // ------------------------------------------------------------
    // axi4-lite read channel
    // ------------------------------------------------------------
    logic        rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0]  rresp_ff;
    logic        nxt_rvalid;
    logic [31:0] nxt_rdata;
    logic [1:0]  nxt_rresp;
    logic [31:0] status_word;

    always_comb
    begin
        status_word = '0;
        status_word[cmp_pkg::ST_MODES +: cmp_pkg::CH_N]   = modes_ff;
        status_word[cmp_pkg::ST_CONVRST]                  = ~conv_rst_n_ff;
        status_word[cmp_pkg::ST_CLEAR]                    = clear_s;
        status_word[cmp_pkg::ST_SWITCH]                   = switch_s;
        status_word[cmp_pkg::ST_MUXSEL +: cmp_pkg::SEL_W] = mux_sel_ff;
    end

    assign s_axi_arready = ~rvalid_ff;

    // one read in flight; unmapped addresses read zero with slverr
    always_comb
    begin
        nxt_rvalid = rvalid_ff;
        nxt_rdata  = rdata_ff;
        nxt_rresp  = rresp_ff;
        if (s_axi_arvalid && s_axi_arready)
        begin
            nxt_rvalid = 1'b1;
            nxt_rresp  = cmp_pkg::RESP_OKAY;
            unique case (s_axi_araddr)
                cmp_pkg::REG_STATUS: nxt_rdata = status_word;
                cmp_pkg::REG_CONV:   nxt_rdata = {16'h0000, conv_cfg_ff};
                cmp_pkg::REG_SHIFT:  nxt_rdata = {24'h000000, shift_ff};
                default:
                begin
                    nxt_rdata = '0;
                    nxt_rresp = cmp_pkg::RESP_SLVERR;
                end
            endcase
        end
        else if (rvalid_ff && s_axi_rready)
        begin
            nxt_rvalid = 1'b0;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= '0;
            rresp_ff  <= cmp_pkg::RESP_OKAY;
        end
        else
        begin
            rvalid_ff <= nxt_rvalid;
            rdata_ff  <= nxt_rdata;
            rresp_ff  <= nxt_rresp;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign mux_select              = mux_sel_ff;
    assign converter_reset_n       = conv_rst_n_ff;
    assign converter_config        = conv_cfg_ff;
    assign opto_drive              = modes_ff;
    // bit 7 is the leftmost lamp: cm 4..1 then non-cm 4..1
    assign indicator_left_to_right = modes_ff;
    assign s_axi_bvalid            = bvalid_ff;
    assign s_axi_bresp             = bresp_ff;
    assign s_axi_rvalid            = rvalid_ff;
    assign s_axi_rdata             = rdata_ff;
    assign s_axi_rresp             = rresp_ff;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    mux_route_a: assert property (@(posedge sys_clk) disable iff (reset)
        switch_s |=> mux_select == {$past(pin_sync_ff[cmp_pkg::PIN_MUXHI]),
                                    $past(pin_sync_ff[cmp_pkg::PIN_SDATA]),
                                    $past(pin_sync_ff[cmp_pkg::PIN_SCLK])})
        else $error("mux select does not follow the routed lines");

    mux_hold_a: assert property (@(posedge sys_clk) disable iff (reset)
        !switch_s |=> $stable(mux_select))
        else $error("mux select moved during programming");

    mode_cause_a: assert property (@(posedge sys_clk) disable iff (reset)
        !$stable(modes_ff) |-> $past(!clear_s) || $past(sclk_rise && !switch_s))
        else $error("modes changed without clear or shift pulse");

    mode_load_a: assert property (@(posedge sys_clk) disable iff (reset)
        (sclk_rise && !switch_s && clear_s) |=> modes_ff == $past(shift_ff))
        else $error("applying pulse did not load the shifted byte");

    conv_hold_a: assert property (@(posedge sys_clk) disable iff (reset)
        !switch_s [*2] |-> !converter_reset_n)
        else $error("converter not in reset while programming");

    clear_modes_a: assert property (@(posedge sys_clk) disable iff (reset)
        !clear_s |=> opto_drive == 8'h00 && indicator_left_to_right == 8'h00)
        else $error("clear did not return channels to voltage");

    conv_release_a: assert property (@(posedge sys_clk) disable iff (reset)
        $rose(switch_s) |=> converter_reset_n)
        else $error("converter not released after programming");

    cfg_default_a: assert property (@(posedge sys_clk) disable iff (reset)
        !converter_reset_n |=> converter_config == cmp_pkg::CONV_CFG_DEFAULT)
        else $error("converter configuration survived reset");

    lamp_opto_a: assert property (@(posedge sys_clk) disable iff (reset)
        indicator_left_to_right == opto_drive)
        else $error("indicator disagrees with optocoupler");

    lamp_order_a: assert property (@(posedge sys_clk) disable iff (reset)
        (sclk_rise && !switch_s && clear_s) |=> indicator_left_to_right[7] == $past(shift_ff[7]))
        else $error("leftmost indicator not first shifted bit");

endmodule : cmp_mode_programmer

// file: cmp_host_model.sv
// host gpio model: drives the programming pins and the rc-derived clear line
module cmp_host_model
#(
    parameter int RC_CYC = 16,  // rc charge or discharge time in cycles
    parameter int HOLD   = 4    // each pin level stands longer than the 3-flop latency
)
(
    input  wire logic sys_clk,
    output logic      isolated_switch_control = 1'b1,
    output logic      shift_clock_line        = 1'b1,
    output logic      serial_data_line        = 1'b0,
    output logic      register_clear_line     = 1'b1,
    output logic      channel_select_high     = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;

    int rc_ff = RC_CYC;  // rc node charge, full at start

    // ------------------------------------------------
    // rc network
    // ------------------------------------------------
    // switch high lets the register side idle high, so the node stays charged
    always @(posedge sys_clk)
    begin
        if (isolated_switch_control || shift_clock_line)
            rc_ff <= (rc_ff < RC_CYC) ? rc_ff + 1 : rc_ff;
        else
            rc_ff <= (rc_ff > 0) ? rc_ff - 1 : rc_ff;
        if (rc_ff == RC_CYC)
            register_clear_line <= 1'b1;
        else if (rc_ff == 0)
            register_clear_line <= 1'b0;
    end

    // ------------------------------------------------
    // pin sequences
    // ------------------------------------------------
    task automatic step(input logic sw, input logic sc, input logic sd);
        isolated_switch_control <= sw;
        shift_clock_line        <= sc;
        serial_data_line        <= sd;
        repeat (HOLD) @(posedge sys_clk);
    endtask : step

    // measurement: the two lines carry select bits 0 and 1
    task automatic measure(input logic [2:0] sel);
        channel_select_high <= sel[2];
        step(1'b1, sel[0], sel[1]);
    endtask : measure

    // rc intervals are timed by counts, never sensed
    task automatic program_modes(input logic [7:0] modes);
        step(1'b0, 1'b1, 1'b0);
        step(1'b0, 1'b0, 1'b0);
        repeat (RC_CYC) @(posedge sys_clk);
        for (int i = 7; i >= 0; i--)
        begin
            step(1'b0, 1'b0, modes[i]);
            step(1'b0, 1'b1, modes[i]);
        end
        step(1'b0, 1'b1, 1'b0);
        repeat (RC_CYC) @(posedge sys_clk);
        step(1'b0, 1'b0, 1'b0);
        step(1'b0, 1'b1, 1'b0);
        step(1'b1, 1'b1, 1'b0);
    endtask : program_modes
endmodule : cmp_host_model

// file: testbench.sv
// self-checking bench: host pin model and axi4-lite master around the programmer
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic        sys_clk = 1'b0;  // 4 ns period
    logic        reset   = 1'b1;  // synchronous, active high
    logic        isolated_switch_control, shift_clock_line, serial_data_line;
    logic        register_clear_line, channel_select_high, converter_reset_n;
    logic [2:0]  mux_select;
    logic [15:0] converter_config, cfg;
    logic [7:0]  opto_drive, indicator_left_to_right, modes;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rnd;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [33:0] rnote;   // oldest read note {resp, data}
    logic [33:0] rq[$];   // read notes
    logic [1:0]  bq[$];   // write response notes
    int          bad_count = 0;
    int          total_checks = 0;
    int          seed = 32'ha80a546a;

    cmp_mode_programmer i_cmp_mode_programmer (.*);
    cmp_host_model      i_cmp_host_model (.*);

    initial
    begin
        forever #2 sys_clk = ~sys_clk;
    end

    // ------------------------------------------------
    // compare, notes and bus tasks
    // ------------------------------------------------
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp

    // clear and switch read high outside programming
    function automatic logic [31:0] st(input logic [7:0] m, input logic [2:0] mx);
        return {18'h0, mx, 1'b1, 1'b1, 1'b0, m};
    endfunction : st

    // each answer on the bus takes the oldest note
    always @(posedge sys_clk)
    begin
        if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
        begin
            rnote = rq.pop_front();
            cmp("rdata", rnote[31:0], s_axi_rdata);
            cmp("rresp", {30'h0, rnote[33:32]}, {30'h0, s_axi_rresp});
        end
        if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
            cmp("bresp", {30'h0, bq.pop_front()}, {30'h0, s_axi_bresp});
    end

    // address and data offered together, each released once taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                          input logic [1:0] r = cmp_pkg::RESP_OKAY);
        @(posedge sys_clk);
        bq.push_back(r);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!(s_axi_bvalid && s_axi_bready));
        s_axi_bready <= 1'b0;
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] d,
                          input logic [1:0] r = cmp_pkg::RESP_OKAY);
        @(posedge sys_clk);
        rq.push_back({r, d});
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!(s_axi_rvalid && s_axi_rready));
        s_axi_rready <= 1'b0;
    endtask : axi_rd

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : results

    // a hang counts as a mismatch; the tests need about eight hundred cycles
    initial
    begin
        repeat (5000) @(posedge sys_clk);
        bad_count++;
        results();
    end

    // ------------------------------------------------
    // tests
    // ------------------------------------------------
    initial
    begin
        repeat (4) @(posedge sys_clk);
        reset <= 1'b0;
        repeat (8) @(posedge sys_clk);
        axi_rd(cmp_pkg::REG_STATUS, st(8'h00, 3'h1));
        axi_wr(cmp_pkg::REG_STATUS, 32'hffffffff, 4'hf, cmp_pkg::RESP_SLVERR);
        axi_rd(cmp_pkg::REG_STATUS, st(8'h00, 3'h1));
        axi_rd(8'h0c, 32'h0, cmp_pkg::RESP_SLVERR);
        axi_rd(cmp_pkg::REG_SHIFT, 32'h0);
        axi_rd(cmp_pkg::REG_CONV, 32'h0);
        axi_wr(cmp_pkg::REG_CONV, 32'hdead1234, 4'hf);
        axi_wr(cmp_pkg::REG_CONV, 32'h000056ab, 4'h1);
        axi_rd(cmp_pkg::REG_CONV, 32'h000012ab);
        cmp("converter_config", 32'h12ab, {16'h0, converter_config});
        $display("test registers done");
        // toggling the lines while routed to the mux must not touch the modes
        for (int i = 0; i < 8; i++)
        begin
            i_cmp_host_model.measure(i[2:0]);
            cmp("mux_select", i, {29'h0, mux_select});
            cmp("opto_drive", 32'h0, {24'h0, opto_drive});
        end
        $display("test select done");
        for (int k = 0; k < 5; k++)
        begin
            rnd   = $random(seed);
            modes = (k == 0) ? 8'h46 : (k == 1) ? 8'hff : rnd[7:0];
            cfg   = rnd[23:8];
            axi_wr(cmp_pkg::REG_CONV, 32'h0000ffff, 4'hf);
            fork
                i_cmp_host_model.program_modes(modes);
                begin
                    repeat (50) @(posedge sys_clk);
                    cmp("converter_reset_n", 32'h0, {31'h0, converter_reset_n});
                    cmp("opto_drive", 32'h0, {24'h0, opto_drive});
                    cmp("mux_select", (k == 0) ? 7 : 5, {29'h0, mux_select});
                    axi_wr(cmp_pkg::REG_CONV, {16'h0, cfg}, 4'hf);
                end
            join
            repeat (2) @(posedge sys_clk);
            cmp("opto_drive", {24'h0, modes}, {24'h0, opto_drive});
            cmp("indicator", {24'h0, modes}, {24'h0, indicator_left_to_right});
            cmp("converter_reset_n", 32'h1, {31'h0, converter_reset_n});
            axi_rd(cmp_pkg::REG_STATUS, st(modes, 3'h5));
            axi_rd(cmp_pkg::REG_CONV, 32'h0);
            axi_rd(cmp_pkg::REG_SHIFT, {24'h0, modes[6:0], 1'b0});
            axi_wr(cmp_pkg::REG_CONV, {16'h0, cfg}, 4'hf);
            axi_rd(cmp_pkg::REG_CONV, {16'h0, cfg});
        end
        $display("test programming done");
        results();
    end
endmodule : testbench
